// ---- pld_detector.sv ----
// Phase loss and lock detector with its AXI4-Lite register slave and interrupt.
// Assumes phase error magnitudes arrive synchronous to aclk from the phase detector.
//
// Contract
// RQ1 - Coarse detector disabled never raises phase loss.
// RQ2 - Enabled coarse error above limit raises loss.
// RQ3 - Coarse limit counts whole input clock cycles.
// RQ4 - Fine window size resets to code two.
// RQ5 - Lock after qualifying time; excursion loses at once.
// RQ6 - Fine enable bit gates the fine detector.
// RQ7 - Inactivity forces loss only when bit set.
// RQ8 - Lost is OR of losses; lock clears it.
`timescale 1ns/1ns
module pld_detector
  import pld_pkg::*;
#(
  parameter int unsigned QUAL_CYC = QUAL_CYCLES
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [AXI_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [AXI_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic [7:0]        coarse_err_ui,
  input  wire logic [8:0]        fine_err_deg,
  input  wire logic              ref_inactive,
  output logic                   phase_lost,
  output logic                   phase_locked,
  output logic                   irq
);

  // Address decode shared by the read and the write path.
  function automatic pld_sel_e reg_sel(input logic [AXI_AW-1:0] a);
    logic [AXI_AW-3:0] idx;
    idx = a[AXI_AW-1:2];
    if (a[1:0] != 2'h0) begin
      reg_sel = SEL_NONE;
    end else if (idx == (AXI_AW-2)'(IDX_FINE)) begin
      reg_sel = SEL_FINE;
    end else if (idx == (AXI_AW-2)'(IDX_COARSE)) begin
      reg_sel = SEL_COARSE;
    end else if (idx == (AXI_AW-2)'(IDX_STATUS)) begin
      reg_sel = SEL_STATUS;
    end else if (idx == (AXI_AW-2)'(IDX_MASK)) begin
      reg_sel = SEL_MASK;
    end else if (idx == (AXI_AW-2)'(IDX_STATE)) begin
      reg_sel = SEL_STATE;
    end else begin
      reg_sel = SEL_NONE;
    end
  endfunction

  // All state but the lock qualifier's counter lives in one record; the comb process builds its next value.
  pld_state_s q;
  pld_state_s d;

  // Decision terms and bus decode, all combinational from the state and the inputs.
  logic       coarse_loss;
  logic       fine_loss;
  logic       inact_loss;
  logic       in_window;
  logic       loss_now;
  logic       qual_good;
  logic       qual_done;
  logic [9:0] win_thr;
  logic [1:0] ev_set;
  logic [1:0] ev_clr;
  logic       wr_fire;
  pld_sel_e   wr_sel;
  pld_sel_e   rd_sel;
  logic [7:0] fine_byte;
  logic [7:0] coarse_byte;

  // Loss sources. The coarse error is in whole unit intervals, so the limit compares directly.
  // The threshold is one bit wider than the error, so the widest codes never wrap.
  assign win_thr     = 10'(q.fine.win * WIN_STEP_DEG);
  assign in_window   = ({1'b0, fine_err_deg} <= win_thr);
  assign coarse_loss = q.coarse.en && (coarse_err_ui > {4'h0, q.coarse.limit}); // [RQ1] [RQ2] [RQ3]
  assign fine_loss   = q.fine.en && !in_window;                            // [RQ5] [RQ6]
  assign inact_loss  = q.fine.inactivity_forces_loss && ref_inactive;     // [RQ7]
  assign loss_now    = coarse_loss || fine_loss || inact_loss;            // [RQ8]

  // With the fine detector off, lock is qualified on the absence of any other loss.
  assign qual_good = !loss_now && (q.fine.en ? in_window : 1'b1);         // [RQ5] [RQ6]

  pld_lock_qual #(
    .CYCLES (QUAL_CYC)
  ) u_qual (
    .aclk    (aclk),
    .aresetn (aresetn),
    .good_i  (qual_good),
    .done_o  (qual_done)
  );

  // Register images for read back; unused bits read as zero.
  // Narrow mode, wide range and multicycle response are stored but steer nothing here.
  assign fine_byte   = {q.fine.en, q.fine.inactivity_forces_loss, q.fine.narrow_en, 2'h0,
                        q.fine.win};
  assign coarse_byte = {q.coarse.en, q.coarse.wide_range_en,
                        q.coarse.multicycle_response_select, 1'h0, q.coarse.limit};

  // Write is carried out once both address and data are held and no response is pending.
  assign wr_fire = q.aw_have && q.w_have && !q.bvalid;
  assign wr_sel  = reg_sel(q.awaddr);
  assign rd_sel  = reg_sel(s_axi_araddr);
  assign ev_clr  = (wr_fire && wr_sel == SEL_STATUS && q.wlane) ? q.wbyte[1:0] : 2'h0;

  // Next state of the bus slave, the configuration, the lost flag and the event bits.
  always_comb begin
    d = q;
    // Address and data are captured independently, so they may arrive in either order.
    if (s_axi_awvalid && s_axi_awready) begin
      d.aw_have = 1'b1;
      d.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      d.w_have = 1'b1;
      d.wbyte  = s_axi_wdata[7:0];
      d.wlane  = s_axi_wstrb[0];
    end
    // The write response stands until the master takes it.
    if (q.bvalid && s_axi_bready) begin
      d.bvalid = 1'b0;
    end
    // A write without byte lane zero is answered but stores nothing.
    if (wr_fire) begin
      d.aw_have = 1'b0;
      d.w_have  = 1'b0;
      d.bvalid  = 1'b1;
      d.bresp   = (wr_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      if (q.wlane) begin
        unique case (wr_sel)
          SEL_FINE: begin
            d.fine.en                     = q.wbyte[BIT_EN];
            d.fine.inactivity_forces_loss = q.wbyte[BIT_OPT6];
            d.fine.narrow_en              = q.wbyte[BIT_OPT5];
            d.fine.win                    = q.wbyte[2:0];
          end
          SEL_COARSE: begin
            d.coarse.en                         = q.wbyte[BIT_EN];
            d.coarse.wide_range_en              = q.wbyte[BIT_OPT6];
            d.coarse.multicycle_response_select = q.wbyte[BIT_OPT5];
            d.coarse.limit                      = q.wbyte[3:0];
          end
          SEL_MASK: begin
            d.mask = q.wbyte[1:0];
          end
          SEL_STATUS, SEL_STATE, SEL_NONE: begin
          end
        endcase
      end
    end
    // Read data are registered and stand until the master takes them.
    if (q.rvalid && s_axi_rready) begin
      d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      d.rvalid = 1'b1;
      d.rresp  = (rd_sel == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
      unique case (rd_sel)
        SEL_FINE:   d.rdata = {24'h0, fine_byte};
        SEL_COARSE: d.rdata = {24'h0, coarse_byte};
        SEL_STATUS: d.rdata = {30'h0, q.status};
        SEL_MASK:   d.rdata = {30'h0, q.mask};
        SEL_STATE:  d.rdata = {26'h0, in_window, inact_loss, fine_loss, coarse_loss, !q.lost,
                               q.lost};
        SEL_NONE:   d.rdata = 32'h0;
      endcase
    end
    // Lost is set by any loss and only a qualified lock clears it.
    if (loss_now) begin
      d.lost = 1'b1;                                                      // [RQ8] [RQ5]
    end else if (qual_done) begin
      d.lost = 1'b0;                                                      // [RQ8] [RQ5]
    end
    // An event in the clearing cycle survives, since the set is applied last.
    ev_set = 2'h0;
    ev_set[EV_LOSS] = d.lost && !q.lost;
    ev_set[EV_LOCK] = !d.lost && q.lost;
    d.status = (q.status & ~ev_clr) | ev_set;
  end

  // State register; configuration takes its documented defaults.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q        <= '0;
      q.fine   <= pld_fine_s'({FINE_RST[7:5], FINE_RST[2:0]});        // [RQ4]
      q.coarse <= pld_coarse_s'({COARSE_RST[7:5], COARSE_RST[3:0]});
      // Lost starts set, so lock must be qualified before it is ever declared.
      q.lost   <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // Ready terms are combinational; one transaction of each kind is held at a time.
  assign s_axi_awready = !q.aw_have && !q.bvalid;
  assign s_axi_wready  = !q.w_have && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign phase_lost    = q.lost;
  assign phase_locked  = !q.lost;
  assign irq           = |(q.status & q.mask);

  // Checks on the decision logic.
  chk_coarse_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ1]
    !q.coarse.en && !q.fine.en && !q.fine.inactivity_forces_loss && !q.lost |=> !q.lost)
    else $error("Loss raised with all detectors disabled.");

  chk_coarse_trip: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
    q.coarse.en && (coarse_err_ui > {4'h0, q.coarse.limit}) |=> q.lost)
    else $error("Coarse error above limit did not raise loss.");

  chk_coarse_edge: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ3]
    q.coarse.en && !fine_loss && !inact_loss && !q.lost
    && (coarse_err_ui == {4'h0, q.coarse.limit}) |=> !q.lost)
    else $error("Coarse error equal to limit raised loss.");

  chk_fine_default: assert property (@(posedge aclk) // [RQ4]
    !aresetn |=> (q.fine.win == FINE_WIN_RST) && q.fine.en)
    else $error("Fine window did not reset to its default.");

  chk_fine_trip: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    q.fine.en && ({1'b0, fine_err_deg} > win_thr) |=> q.lost)
    else $error("Fine excursion did not raise loss at once.");

  chk_lock_qual: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    $fell(q.lost) |-> $past(qual_done) && !$past(loss_now))
    else $error("Lock declared without qualification.");

  chk_fine_gate: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ6]
    !q.fine.en && !coarse_loss && !inact_loss && !q.lost
    && ({1'b0, fine_err_deg} > win_thr) |=> !q.lost)
    else $error("Disabled fine detector raised loss.");

  chk_inact_on: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
    q.fine.inactivity_forces_loss && ref_inactive |=> q.lost)
    else $error("Inactivity did not force loss.");

  chk_inact_off: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
    !q.fine.inactivity_forces_loss && !coarse_loss && !fine_loss && ref_inactive
    && !q.lost |=> !q.lost)
    else $error("Inactivity forced loss while not selected.");

  chk_lost_hold: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
    q.lost && !qual_done |=> q.lost)
    else $error("Lost cleared without a qualified lock.");

  // Checks on the event bits and the lock qualifier; the span check needs two or more cycles.
  chk_loss_event: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
    $rose(q.lost) |-> q.status[EV_LOSS])
    else $error("Loss event bit not set when loss was raised.");

  chk_lock_event: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    $fell(q.lost) |-> q.status[EV_LOCK])
    else $error("Lock event bit not set when lock was declared.");

  chk_qual_restart: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    !qual_good |=> !qual_done)
    else $error("Qualifier stayed done after a bad cycle.");

  chk_qual_span: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    $rose(qual_done) |-> $past(qual_good) && $past(qual_good, 2))
    else $error("Qualifier finished without a run of good cycles.");

  chk_coarse_qual: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ2]
    q.coarse.en && (coarse_err_ui > {4'h0, q.coarse.limit}) |=> !qual_done)
    else $error("Coarse excursion did not stop lock qualification.");

  chk_inact_qual: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
    q.fine.inactivity_forces_loss && ref_inactive |=> !qual_done)
    else $error("Inactivity did not stop lock qualification.");

  chk_fine_qual: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ5]
    q.fine.en && !in_window |=> !qual_done)
    else $error("Fine excursion did not stop lock qualification.");

  cov_loss: cover property (@(posedge aclk) disable iff (!aresetn) $rose(q.lost));
  cov_relock: cover property (@(posedge aclk) disable iff (!aresetn) $fell(q.lost));
  cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(irq));
  cov_write: cover property (@(posedge aclk) disable iff (!aresetn) wr_fire ##1 q.bvalid);
  cov_inact: cover property (@(posedge aclk) disable iff (!aresetn) inact_loss ##1 q.lost);

endmodule // pld_detector

// ---- pld_pkg.sv ----
// Constants, register map and carrier types for the phase loss and lock detector.
// Assumes a single 250 MHz clock domain and an AXI4-Lite register port with 32-bit data.
package pld_pkg;

  // Clock rate and the lock qualification time.
  localparam int unsigned CLK_KHZ      = 250000;
  localparam int unsigned QUAL_TIME_MS = 1000;
  localparam int unsigned QUAL_CYCLES  = QUAL_TIME_MS * CLK_KHZ;

  // Register bus geometry.
  localparam int unsigned AXI_AW = 12;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_FINE   = 8'h73;
  localparam logic [7:0] IDX_COARSE = 8'h74;
  localparam logic [7:0] IDX_STATUS = 8'h75;
  localparam logic [7:0] IDX_MASK   = 8'h76;
  localparam logic [7:0] IDX_STATE  = 8'h77;

  // Values after reset.
  localparam logic [7:0] FINE_RST   = 8'hA2;
  localparam logic [7:0] COARSE_RST = 8'h85;
  localparam logic [2:0] FINE_WIN_RST = 3'h2;

  // Field positions shared by both configuration registers.
  localparam int unsigned BIT_EN    = 7;
  localparam int unsigned BIT_OPT6  = 6;
  localparam int unsigned BIT_OPT5  = 5;

  // Fine window step in degrees per code of the window size field.
  localparam int unsigned WIN_STEP_DEG = 90;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Status and mask bit positions.
  localparam int unsigned EV_LOSS = 0;
  localparam int unsigned EV_LOCK = 1;

  typedef enum logic [2:0] {
    SEL_NONE   = 3'b000,
    SEL_FINE   = 3'b001,
    SEL_COARSE = 3'b010,
    SEL_STATUS = 3'b011,
    SEL_MASK   = 3'b100,
    SEL_STATE  = 3'b101
  } pld_sel_e;

  typedef struct packed {
    logic       en;
    logic       inactivity_forces_loss;
    logic       narrow_en;
    logic [2:0] win;
  } pld_fine_s;

  typedef struct packed {
    logic       en;
    logic       wide_range_en;
    logic       multicycle_response_select;
    logic [3:0] limit;
  } pld_coarse_s;

  typedef struct packed {
    logic              aw_have;
    logic [AXI_AW-1:0] awaddr;
    logic              w_have;
    logic [7:0]        wbyte;
    logic              wlane;
    logic              bvalid;
    logic [1:0]        bresp;
    logic              rvalid;
    logic [31:0]       rdata;
    logic [1:0]        rresp;
    pld_fine_s         fine;
    pld_coarse_s       coarse;
    logic [1:0]        status;
    logic [1:0]        mask;
    logic              lost;
  } pld_state_s;

endpackage

// ---- pld_lock_qual.sv ----
// Lock qualification timer: counts cycles of uninterrupted good phase.
// Assumes the caller drops good_i for at least one cycle on every excursion.
`timescale 1ns/1ns
module pld_lock_qual
  import pld_pkg::*;
#(
  parameter int unsigned CYCLES = QUAL_CYCLES,
  parameter int unsigned CW     = $clog2(CYCLES + 1)
) (
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic good_i,
  output logic      done_o
);

  typedef struct packed {
    logic [CW-1:0] cnt;
    logic          done;
  } pld_qual_s;

  localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

  pld_qual_s q;
  pld_qual_s d;

  // Any bad cycle restarts the count, so only an unbroken stretch qualifies.
  always_comb begin
    d = q;
    if (!good_i) begin
      d.cnt  = '0;
      d.done = 1'b0;
    end else if (!q.done) begin
      if (q.cnt == LAST) begin
        d.done = 1'b1;
      end else begin
        d.cnt = q.cnt + CW'(1);
      end
    end
  end

  // State register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = q.done;

endmodule // pld_lock_qual

// ---- pld_ref_model.sv ----
// Behavioural model of the tracked reference: presents phase error to the detector.
// Assumes the bench sets its targets by non-blocking assignment at a rising edge of aclk.
`timescale 1ns/1ns
module pld_ref_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] tgt_ui,
  input  wire logic [8:0] tgt_deg,
  input  wire logic       tgt_idle,
  input  wire logic       slow,
  output logic      [7:0] coarse_err_ui,
  output logic      [8:0] fine_err_deg,
  output logic            ref_inactive
);
  // A slow reference drifts one whole cycle per clock, so a coarse limit is crossed step
  // by step instead of being jumped over; a prompt one moves at once.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coarse_err_ui <= 8'h00;
      fine_err_deg  <= 9'h000;
      ref_inactive  <= 1'h0;
    end else begin
      if (!slow || coarse_err_ui == tgt_ui) coarse_err_ui <= tgt_ui;
      else if (coarse_err_ui < tgt_ui) coarse_err_ui <= coarse_err_ui + 8'h01;
      else coarse_err_ui <= coarse_err_ui - 8'h01;
      fine_err_deg <= tgt_deg;
      ref_inactive <= tgt_idle;
    end
  end
endmodule // pld_ref_model

// ---- pld_detector_tb.sv ----
// Self-checking bench for the phase loss and lock detector, against a behavioural model.
// Assumes a shortened lock qualification count and the reference model beside the design.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("unexpected %s exp %0h got %0h", nm, e, g); end end
module pld_detector_tb;
  import pld_pkg::*;
  localparam int unsigned QC = 8;
  logic              aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, t_idle = 1'h0;
  logic [AXI_AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [31:0]       s_axi_wdata = '0, s_axi_rdata, rd_v;
  logic [3:0]        s_axi_wstrb = 4'hF;
  logic              s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic              s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, s_axi_awready, s_axi_wready;
  logic              s_axi_bvalid, s_axi_arready, s_axi_rvalid, ref_inactive, irq;
  logic              phase_lost, phase_locked;
  logic [1:0]        s_axi_bresp, s_axi_rresp, resp_v;
  logic [7:0]        t_ui = 8'h00, coarse_err_ui;
  logic [8:0]        t_deg = 9'h000, fine_err_deg;
  integer            seed = 66;
  int                mismatches = 0, total_checks = 0, fine_m = 'hA2, coarse_m = 'h85;
  int                status_m = 0, mask_m = 0, lost_m = 1, lim;
  // Free-running 250 MHz clock.
  always #2 aclk = ~aclk;
  pld_detector #(.QUAL_CYC(QC)) i_pld_detector (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .coarse_err_ui, .fine_err_deg, .ref_inactive,
    .phase_lost, .phase_locked, .irq
  );
  pld_ref_model i_pld_ref_model (
    .aclk, .aresetn, .tgt_ui(t_ui), .tgt_deg(t_deg), .tgt_idle(t_idle), .slow,
    .coarse_err_ui, .fine_err_deg, .ref_inactive
  );
  // Loss decision of the model; each window code step is worth 90 degrees.
  function automatic bit loss_f(input int c, input int f, input int u, input int d, input bit n);
    return (c[7] && u > c[3:0]) || (f[7] && d > f[2:0] * 90) || (f[6] && n);
  endfunction
  // One AXI4-Lite transfer; handshakes are sampled at the falling edge, where all is settled.
  task automatic xfer(input bit w, input logic [7:0] i, input logic [31:0] d);
    bit pa, pw, pb, ha, hw;
    int n;
    @(posedge aclk);
    pa = 1;
    pw = w;
    pb = 1;
    n = 0;
    if (w) begin
      s_axi_awaddr <= AXI_AW'({i, 2'h0});
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
    end else begin
      s_axi_araddr <= AXI_AW'({i, 2'h0});
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
    end
    while (pb && n < 64) begin
      @(negedge aclk);
      ha = pa && (w ? s_axi_awready : s_axi_arready);
      hw = pw && s_axi_wready;
      pb = !(w ? s_axi_bvalid : s_axi_rvalid);
      resp_v = w ? s_axi_bresp : s_axi_rresp;
      rd_v = s_axi_rdata;
      @(posedge aclk);
      if (ha && w) s_axi_awvalid <= 1'h0;
      if (ha && !w) s_axi_arvalid <= 1'h0;
      if (hw) s_axi_wvalid <= 1'h0;
      pa = pa && !ha;
      pw = pw && !hw;
      n++;
    end
    s_axi_bready <= 1'h0;
    s_axi_rready <= 1'h0;
    `CHK("xfer_done", 1'h0, pb)
    `CHK("resp", (i >= IDX_FINE && i <= IDX_STATE) ? RESP_OKAY : RESP_SLVERR, resp_v)
  endtask
  // Register write that also updates the model's copy of the register.
  task automatic wr(input logic [7:0] i, input int d);
    xfer(1'h1, i, d);
    if (i == IDX_FINE) fine_m = d;
    if (i == IDX_COARSE) coarse_m = d;
    if (i == IDX_MASK) mask_m = d & 3;
    if (i == IDX_STATUS) status_m &= ~d;
  endtask
  task automatic rdc(input logic [7:0] i, input int e, input string nm);
    xfer(1'h0, i, 32'h0);
    `CHK(nm, 32'(e), rd_v)
  endtask
  task automatic irq_chk;
    @(negedge aclk);
    `CHK("irq", |(status_m & mask_m), irq)
  endtask
  // Present a phase condition and wait long enough for loss, or for a full lock qualification.
  task automatic apply(input logic [7:0] u, input logic [8:0] d, input logic n);
    bit l;
    @(posedge aclk);
    t_ui <= u;
    t_deg <= d;
    t_idle <= n;
    l = loss_f(coarse_m, fine_m, u, d, n);
    repeat (l ? 24 : QC + 24) @(posedge aclk);
    @(negedge aclk);
    `CHK("phase_lost", l, phase_lost)
    `CHK("phase_locked", !l, phase_locked)
    if (l && !lost_m) status_m |= 1;
    else if (!l && lost_m) status_m |= 2;
    lost_m = l;
    `CHK("irq", |(status_m & mask_m), irq)
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence: registers, coarse limits, fine windows, inactivity and interrupt.
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    rdc(IDX_FINE, 32'hA2, "fine");
    rdc(IDX_COARSE, 32'h85, "coarse");
    @(negedge aclk);
    `CHK("lost_rst", 1'h1, phase_lost)
    wr(IDX_FINE, 32'hFF);
    rdc(IDX_FINE, 32'hE7, "fine_rw");
    wr(IDX_COARSE, 32'hFF);
    rdc(IDX_COARSE, 32'hEF, "coarse_rw");
    rdc(8'h78, 32'h0, "unmapped");
    wr(8'h78, 32'h1);
    wr(IDX_FINE, 32'hA2);
    $display("test registers done");
    apply(8'h00, 9'h000, 1'h0);
    slow <= 1'h1;
    for (int k = 0; k < 3; k++) begin
      lim = (k * 15) / 2;
      wr(IDX_COARSE, 32'h80 | lim);
      apply(8'(lim), 9'({$random(seed)} % 181), 1'h0);
      apply(8'(lim + 1), 9'h000, 1'h0);
      apply(8'({$random(seed)} % (lim + 1)), 9'h000, 1'h0);
    end
    slow <= 1'h0;
    wr(IDX_COARSE, 32'h0F);
    apply(8'hC8, 9'h000, 1'h0);
    $display("test coarse done");
    // Mid-run reset: configuration, events and the lost flag return to their defaults.
    @(posedge aclk);
    aresetn <= 1'h0;
    t_ui <= 8'h00;
    repeat (4) @(posedge aclk);
    aresetn <= 1'h1;
    fine_m = 'hA2;
    coarse_m = 'h85;
    status_m = 0;
    mask_m = 0;
    lost_m = 1;
    rdc(IDX_COARSE, 32'h85, "coarse_rst2");
    rdc(IDX_FINE, 32'hA2, "fine_rst2");
    @(negedge aclk);
    `CHK("lost_rst2", 1'h1, phase_lost)
    wr(IDX_COARSE, 32'h0F);
    $display("test reset done");
    for (int c = 0; c < 6; c++) begin
      wr(IDX_FINE, 32'h80 | c);
      apply(8'h00, 9'(c * 90), 1'h0);
      apply(8'h00, 9'(c * 90 + 1), 1'h0);
    end
    wr(IDX_FINE, 32'h87);
    apply(8'h00, 9'h1FF, 1'h0);
    wr(IDX_FINE, 32'h02);
    apply(8'h00, 9'h1FF, 1'h0);
    wr(IDX_FINE, 32'hC2);
    apply(8'h00, 9'h000, 1'h1);
    wr(IDX_FINE, 32'h82);
    apply(8'h00, 9'h000, 1'h1);
    $display("test fine done");
    wr(IDX_MASK, 32'h1);
    irq_chk();
    wr(IDX_STATUS, 32'h3);
    irq_chk();
    rdc(IDX_STATUS, status_m, "status");
    apply(8'h00, 9'h1FF, 1'h0);
    wr(IDX_MASK, 32'h2);
    irq_chk();
    apply(8'h00, 9'h000, 1'h0);
    rdc(IDX_STATUS, status_m, "status");
    $display("test interrupt done");
    test_done();
  end
  // Watchdog: the whole sequence needs about a thousand cycles.
  initial begin
    repeat (20000) @(posedge aclk);
    mismatches++;
    test_done();
  end
endmodule // pld_detector_tb
